// [sim/cid_decode_sva.sv]
`timescale 1ns/1ps
// ****************************************************************
// Sequencer and decode checker
// ****************************************************************
module cid_decode_sva (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Fetch and datapath inputs
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic ext_enable_in,
  input wire logic cond_true_in,
  input wire cid_pkg::cid_flags_t alu_flags_in,
  // Sequencing outputs
  input wire cid_pkg::cid_phase_t phase_out,
  input wire logic cycle_end_out,
  input wire logic fetch_take_out,
  input wire logic discard_out,
  input wire logic flush_out,
  input wire logic word2_out,
  // Decode and status outputs
  input wire cid_pkg::cid_dec_t dec_out,
  input wire cid_pkg::cid_flags_t flags_out
);
  logic q4;
  logic redir;

  // Last quarter and redirect cause, shared by several checks
  assign q4 = phase_out == cid_pkg::CID_Q4;
  assign redir = dec_out.pc_change || (dec_out.cond && cond_true_in);

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_phase_walk: assert property (phase_out == cid_pkg::CID_Q1 |=>
    phase_out == cid_pkg::CID_Q2 ##1 phase_out == cid_pkg::CID_Q3
    ##1 q4 ##1 phase_out == cid_pkg::CID_Q1)
    else $error("quarter order broken");
  a_end_gap: assert property (cycle_end_out |=>
    !cycle_end_out [*3] ##1 cycle_end_out)
    else $error("cycle end not one in four");
  a_end_q4: assert property (cycle_end_out == q4
    && fetch_take_out == q4)
    else $error("cycle end off the last quarter");
  a_dec_hold: assert property (!q4 |=> $stable(dec_out))
    else $error("decode changed inside a cycle");
  a_discard_cause: assert property (discard_out |-> q4 && redir
    && !flush_out && !word2_out)
    else $error("discard without redirect");
  a_redirect_drop: assert property (q4 && redir && !flush_out
    && !word2_out && !dec_out.two_word |-> discard_out)
    else $error("redirect kept prefetched word");
  a_flush_len: assert property (discard_out |=>
    flush_out [*4] ##1 !flush_out)
    else $error("flush not one full cycle");
  a_flush_nop: assert property (flush_out |->
    dec_out.cls == cid_pkg::CID_CL_NOP && !dec_out.pc_change)
    else $error("flush cycle not a no-op");
  a_pair_word2: assert property (q4 && dec_out.two_word && !word2_out
    && !flush_out && instr_valid_in
    && instr_in[15:12] == cid_pkg::WORD2_MARK
    |=> word2_out [*4] ##1 !word2_out)
    else $error("second word cycle wrong");
  a_flags_hold: assert property (!q4 || flush_out |=>
    $stable(flags_out))
    else $error("flags moved off cycle end");
  a_flags_merge: assert property (q4 && !flush_out |=> flags_out ==
    (($past(flags_out) & ~$past(dec_out.flag_mask))
    | ($past(alu_flags_in) & $past(dec_out.flag_mask))))
    else $error("flags not merged by mask");
  a_ext_gate: assert property (q4 && !ext_enable_in |=>
    !dec_out.extended)
    else $error("extended decoded while disabled");

  // Main scenarios reached
  c_redirect: cover property (discard_out ##1 flush_out);
  c_pair: cover property (word2_out && dec_out.pc_change);
  c_ext: cover property (dec_out.extended);
endmodule // cid_decode_sva

bind cid_decode cid_decode_sva u_sva (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .instr_in(instr_in),
  .instr_valid_in(instr_valid_in),
  .ext_enable_in(ext_enable_in),
  .cond_true_in(cond_true_in),
  .alu_flags_in(alu_flags_in),
  .phase_out(phase_out),
  .cycle_end_out(cycle_end_out),
  .fetch_take_out(fetch_take_out),
  .discard_out(discard_out),
  .flush_out(flush_out),
  .word2_out(word2_out),
  .dec_out(dec_out),
  .flags_out(flags_out)
);

// [sim/cid_decode_tb_top.sv]
`timescale 1ns/1ps
// ****************************************************************
// Decode block bench
// ****************************************************************
module cid_decode_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] word_r = 16'h0000;
  logic valid_r = 1'b1;
  logic ext_r = 1'b0;
  logic cond_r = 1'b0;
  logic disc_seen = 1'b0;
  cid_pkg::cid_flags_t alu_r = 5'h00;
  logic [15:0] instr_w;
  logic valid_w;
  cid_pkg::cid_phase_t phase_w;
  logic end_w;
  logic take_w;
  logic discard_w;
  logic flush_w;
  logic word2_w;
  cid_pkg::cid_dec_t dec_w;
  cid_pkg::cid_flags_t flags_w;
  int bad_count = 0;
  int checks = 0;

  // 25 MHz core clock
  always #20 clock_in = ~clock_in;

  cid_fetch_model u_fetch (
    .clock_in(clock_in),
    .phase_in(phase_w),
    .word_in(word_r),
    .valid_in(valid_r),
    .instr_out(instr_w),
    .instr_valid_out(valid_w)
  );

  cid_decode u_dut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .instr_in(instr_w),
    .instr_valid_in(valid_w),
    .ext_enable_in(ext_r),
    .cond_true_in(cond_r),
    .alu_flags_in(alu_r),
    .phase_out(phase_w),
    .cycle_end_out(end_w),
    .fetch_take_out(take_w),
    .discard_out(discard_w),
    .flush_out(flush_w),
    .word2_out(word2_w),
    .dec_out(dec_w),
    .flags_out(flags_w)
  );

  // Single compare point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One word per cycle; returns in Q1 with the new decode standing
  task automatic issue(input logic [15:0] w, input logic ct,
                       input logic [4:0] fl);
    while (phase_w !== cid_pkg::CID_Q4) @(negedge clock_in);
    word_r = w;
    cond_r = ct;
    alu_r = fl;
    #1 disc_seen = discard_w;
    @(negedge clock_in);
  endtask

  task automatic final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_reset;
    chk(phase_w, cid_pkg::CID_Q1);
    chk(dec_w.cls, cid_pkg::CID_CL_NOP);
    chk(flags_w, 5'h00);
    rst_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(negedge clock_in);
      chk(phase_w, 4'h2 << i);
      chk({end_w, take_w}, {2{i == 2}});
    end
  endtask

  task automatic t_byte;
    issue(16'h2701, 1'b0, 5'h00);
    chk(dec_w.cls, cid_pkg::CID_CL_BYTE);
    chk(dec_w.f_addr, 8'h01);
    chk(dec_w.dest_file, 1'b1);
    chk(dec_w.bank_sel, 1'b1);
    issue(16'h2480, 1'b0, 5'h00);
    chk(dec_w.f_addr, 8'h80);
    chk(dec_w.dest_file, 1'b0);
    chk(dec_w.bank_sel, 1'b0);
    issue(16'h0E55, 1'b0, 5'h1A);
    chk(flags_w, 5'h1A);
    chk(dec_w.literal, 20'h00055);
    chk(dec_w.lit_width, cid_pkg::CID_LW_8);
    issue(16'h0000, 1'b0, 5'h05);
    chk(flags_w, 5'h1A);
  endtask

  task automatic t_bit;
    for (int b = 0; b < 8; b++) begin
      issue(16'h8155 | (b[15:0] << 9), 1'b0, 5'h00);
      chk(dec_w.cls, cid_pkg::CID_CL_BIT);
      chk(dec_w.bit_num, b);
      chk({dec_w.bank_sel, dec_w.f_addr}, 9'h155);
    end
    // Bit toggle carries no test, so a true condition must not skip
    issue(16'h7155, 1'b1, 5'h00);
    chk({dec_w.cls, dec_w.cond}, {cid_pkg::CID_CL_BIT, 1'b0});
    issue(16'h0000, 1'b1, 5'h00);
    chk({disc_seen, flush_w}, 2'h0);
  endtask

  // Double words, then a stray second word
  task automatic t_pairs;
    issue(16'hEF12, 1'b0, 5'h00);
    chk({dec_w.two_word, word2_w}, 2'h2);
    issue(16'hF345, 1'b0, 5'h00);
    chk(word2_w, 1'b1);
    chk(dec_w.prog_addr, 20'h34512);
    issue(16'hEE25, 1'b0, 5'h00);
    chk({flush_w, word2_w}, 2'h0);
    issue(16'hF0CD, 1'b0, 5'h00);
    chk(dec_w.ptr_sel, 2'h2);
    chk(dec_w.literal, 20'h005CD);
    chk(dec_w.lit_width, cid_pkg::CID_LW_12);
    issue(16'hC123, 1'b0, 5'h00);
    issue(16'hFABC, 1'b0, 5'h00);
    chk(dec_w.src_addr, 12'h123);
    chk(dec_w.dst_addr, 12'hABC);
    issue(16'hF123, 1'b0, 5'h00);
    chk({dec_w.cls, word2_w}, {cid_pkg::CID_CL_NOP, 1'b0});
  endtask

  // Taken skip, untaken skip, branch
  task automatic t_redirect;
    issue(16'hB001, 1'b0, 5'h00);
    chk(dec_w.cond, 1'b1);
    issue(16'h0E11, 1'b1, 5'h00);
    chk(disc_seen, 1'b1);
    chk({flush_w, dec_w.cls}, {1'b1, cid_pkg::CID_CL_NOP});
    issue(16'h0E22, 1'b0, 5'h00);
    chk({flush_w, dec_w.literal}, 21'h00022);
    issue(16'hB001, 1'b0, 5'h00);
    issue(16'h0E33, 1'b0, 5'h00);
    chk({disc_seen, flush_w, dec_w.literal}, 22'h00033);
    issue(16'hD005, 1'b0, 5'h00);
    chk(dec_w.pc_change, 1'b1);
    issue(16'h0E44, 1'b0, 5'h00);
    chk({disc_seen, flush_w}, 2'h3);
  endtask

  task automatic t_ctrl;
    for (int m = 0; m < 4; m++) begin
      issue(16'h0008 + m[15:0], 1'b0, 5'h00);
      chk(dec_w.tbl_mode, m);
    end
    issue(16'h0013, 1'b0, 5'h00);
    chk(dec_w.fast, 1'b1);
    issue(16'h0000, 1'b0, 5'h00);
    issue(16'h0012, 1'b0, 5'h00);
    chk(dec_w.fast, 1'b0);
    issue(16'h0000, 1'b0, 5'h00);
    // Pointer add without a program counter change, so no flush hides it
    ext_r = 1'b1;
    issue(16'hE845, 1'b0, 5'h00);
    chk(dec_w.extended, 1'b1);
    chk({dec_w.ptr_sel, dec_w.literal}, 22'h100005);
    ext_r = 1'b0;
    issue(16'hE845, 1'b0, 5'h00);
    chk({dec_w.cls, dec_w.extended}, {cid_pkg::CID_CL_NOP, 1'b0});
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge clock_in);
    t_reset();
    t_byte();
    t_bit();
    t_pairs();
    t_redirect();
    t_ctrl();
    final_report();
  end

  // Hang guard, far beyond the roughly 160 clock cycles the tests need
  initial begin
    #400000;
    bad_count++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    final_report();
  end
endmodule // cid_decode_tb_top

// [sim/cid_fetch_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Program memory fetch model
// ****************************************************************
module cid_fetch_model (
  // Clock
  input wire logic clock_in,
  // Sequencer view
  input wire cid_pkg::cid_phase_t phase_in,
  // Word chosen by the bench
  input wire logic [15:0] word_in,
  input wire logic valid_in,
  // Fetch bus
  output logic [15:0] instr_out,
  output logic instr_valid_out
);
  logic [15:0] churn_r = 16'h0000;

  // Churn so a stale bus never passes for a held word
  always_ff @(posedge clock_in) begin
    churn_r <= churn_r + 16'h1357;
  end

  // Word stands only through the quarter that takes it
  assign instr_out = (phase_in == cid_pkg::CID_Q4) ? word_in
                     : (~word_in ^ churn_r);
  assign instr_valid_out = (phase_in == cid_pkg::CID_Q4) ? valid_in
                           : churn_r[0];
endmodule // cid_fetch_model

// [verilog/cid_decode.sv]
`timescale 1ns/1ps
// What this block does
// - Decode all 75 core instructions plus the eight extended ones.
// - A single word is 16 bits: opcode plus operand fields.
// - Four instructions span two consecutive words, 32 bits in all.
// - Second words start with four ones; alone they run as no-op.
// - Byte instructions carry file address, destination and access bits.
// - Destination 0 writes working register, 1 writes the file register.
// - Access 0 uses access RAM; access 1 takes bank from bank register.
// - Bit instructions carry file address, access bit and 3-bit bit number.
// - File operand is 8-bit address or 2-bit pointer selector.
// - Register moves give 12-bit source and 12-bit destination addresses.
// - Literal field is 8, 12 or 20 bits depending on instruction.
// - Control words give program address, fast bit, table mode, or nothing.
// - Single word takes one cycle; taken test or jump adds a no-op cycle.
// - Double-word instructions always take two instruction cycles.
// - Each instruction cycle is exactly four oscillator periods.
// - Keep carry, digit carry, zero, overflow and negative flags.
// - Fast bit set on call or return uses shadows; clear leaves them.
// - Table pointer mode: no change, post-inc, post-dec, pre-inc.
module cid_decode (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Fetch side
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  // Datapath side
  input wire logic ext_enable_in,
  input wire logic cond_true_in,
  input wire cid_pkg::cid_flags_t alu_flags_in,
  // Sequencing
  output cid_pkg::cid_phase_t phase_out,
  output logic cycle_end_out,
  output logic fetch_take_out,
  output logic discard_out,
  output logic flush_out,
  output logic word2_out,
  // Decoded instruction and status
  output cid_pkg::cid_dec_t dec_out,
  output cid_pkg::cid_flags_t flags_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  cid_pkg::cid_phase_t phase_r;
  cid_pkg::cid_state_t state_r;
  cid_pkg::cid_dec_t dec_r;
  cid_pkg::cid_dec_t dec_nxt;
  cid_pkg::cid_dec_t merged;
  cid_pkg::cid_flags_t status_r;
  logic [15:0] w;
  logic cycle_end;
  logic redirect;

  // ****************************************************************
  // Quarter-cycle sequencer
  // ****************************************************************
  // Four oscillator periods per instruction cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      phase_r <= cid_pkg::CID_Q1;
    end else begin
      unique case (phase_r)
        cid_pkg::CID_Q1: phase_r <= cid_pkg::CID_Q2;
        cid_pkg::CID_Q2: phase_r <= cid_pkg::CID_Q3;
        cid_pkg::CID_Q3: phase_r <= cid_pkg::CID_Q4;
        cid_pkg::CID_Q4: phase_r <= cid_pkg::CID_Q1;
      endcase
    end
  end

  assign cycle_end = (phase_r == cid_pkg::CID_Q4);

  // Missing fetch word becomes a no-op rather than stale data
  assign w = instr_valid_in ? instr_in : cid_pkg::NOP_WORD;

  // ****************************************************************
  // First-word decode
  // ****************************************************************
  // Layouts per published encodings
  always_comb begin
    dec_nxt = '0;
    dec_nxt.word = w;
    dec_nxt.f_addr = w[7:0];
    dec_nxt.dest_file = w[cid_pkg::DEST_BIT];
    dec_nxt.bank_sel = w[cid_pkg::ACCESS_BIT];
    dec_nxt.literal = {12'h000, w[7:0]};
    dec_nxt.lit_width = cid_pkg::CID_LW_8;
    casez (w)
      // Control group without operands, table and returns
      16'b0000_0000_0000_0000: dec_nxt.cls = cid_pkg::CID_CL_NOP;
      16'b0000_0000_0000_0011,
      16'b0000_0000_0000_0100,
      16'b0000_0000_0000_0101,
      16'b0000_0000_0000_0110: dec_nxt.cls = cid_pkg::CID_CL_CTRL;
      16'b0000_0000_0000_0111: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.flag_mask = cid_pkg::FL_C;
      end
      16'b0000_0000_0000_1???: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.tbl_mode = cid_pkg::cid_tbl_t'(w[1:0]);
      end
      16'b0000_0000_0001_000?,
      16'b0000_0000_0001_001?: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.fast = w[cid_pkg::RET_FAST_BIT];
        dec_nxt.pc_change = 1'b1;
      end
      16'b0000_0000_0001_0100: begin
        dec_nxt.cls = ext_enable_in ? cid_pkg::CID_CL_CTRL
                                    : cid_pkg::CID_CL_NOP;
        dec_nxt.extended = ext_enable_in;
        dec_nxt.pc_change = ext_enable_in;
      end
      16'b0000_0000_1111_1111: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.pc_change = 1'b1;
      end
      16'b0000_0001_0000_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_LIT;
        dec_nxt.literal = {16'h0000, w[3:0]};
      end
      16'b0000_001?_????_????: dec_nxt.cls = cid_pkg::CID_CL_BYTE;
      // Literal group
      16'b0000_1100_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_LIT;
        dec_nxt.pc_change = 1'b1;
      end
      16'b0000_1101_????_????,
      16'b0000_1110_????_????: dec_nxt.cls = cid_pkg::CID_CL_LIT;
      16'b0000_1000_????_????,
      16'b0000_1111_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_LIT;
        dec_nxt.flag_mask = cid_pkg::FL_ALL;
      end
      16'b0000_10??_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_LIT;
        dec_nxt.flag_mask = cid_pkg::FL_ZN;
      end
      // Byte-oriented file operations
      16'b0000_01??_????_????,
      16'b0010_0???_????_????,
      16'b0010_10??_????_????,
      16'b0101_01??_????_????,
      16'b0101_1???_????_????,
      16'b0110_110?_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_BYTE;
        dec_nxt.flag_mask = cid_pkg::FL_ALL;
      end
      16'b0001_????_????_????,
      16'b0100_0???_????_????,
      16'b0101_00??_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_BYTE;
        dec_nxt.flag_mask = cid_pkg::FL_ZN;
      end
      16'b0011_0???_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_BYTE;
        dec_nxt.flag_mask = cid_pkg::FL_CZN;
      end
      16'b0110_101?_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_BYTE;
        dec_nxt.flag_mask = cid_pkg::FL_Z;
      end
      16'b0011_10??_????_????,
      16'b0110_1?0?_????_????,
      16'b0110_111?_????_????: dec_nxt.cls = cid_pkg::CID_CL_BYTE;
      // Skip-on-test byte operations
      16'b0010_11??_????_????,
      16'b0011_11??_????_????,
      16'b0100_1???_????_????,
      16'b0110_0???_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_BYTE;
        dec_nxt.cond = 1'b1;
      end
      // Bit-oriented operations
      16'b0111_????_????_????,
      16'b100?_????_????_????,
      16'b101?_????_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_BIT;
        dec_nxt.bit_num = w[cid_pkg::BITNUM_LSB +: 3];
        dec_nxt.cond = w[15] & w[13]; // Toggle has no
      end
      // Register move, first word carries source
      16'b1100_????_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_MOVE;
        dec_nxt.src_addr = w[11:0];
        dec_nxt.two_word = 1'b1;
      end
      // Relative branch and relative call, 11-bit offset
      16'b1101_????_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.prog_addr = {{9{w[10]}}, w[10:0]};
        dec_nxt.rel_addr = 1'b1;
        dec_nxt.pc_change = 1'b1;
      end
      // Conditional branches, 8-bit offset
      16'b1110_0???_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.prog_addr = {{12{w[7]}}, w[7:0]};
        dec_nxt.rel_addr = 1'b1;
        dec_nxt.cond = 1'b1;
      end
      // Extended pointer arithmetic and literal push
      16'b1110_100?_????_????: begin
        dec_nxt.cls = ext_enable_in ? cid_pkg::CID_CL_LIT
                                    : cid_pkg::CID_CL_NOP;
        dec_nxt.extended = ext_enable_in;
        dec_nxt.ptr_sel = w[cid_pkg::ADDFSR_SEL_LSB +: 2];
        dec_nxt.literal = {14'h0000, w[5:0]};
        dec_nxt.pc_change = ext_enable_in & (&w[7:6]);
      end
      16'b1110_1010_????_????: begin
        dec_nxt.cls = ext_enable_in ? cid_pkg::CID_CL_LIT
                                    : cid_pkg::CID_CL_NOP;
        dec_nxt.extended = ext_enable_in;
      end
      16'b1110_1011_????_????: begin
        dec_nxt.cls = ext_enable_in ? cid_pkg::CID_CL_MOVE
                                    : cid_pkg::CID_CL_NOP;
        dec_nxt.extended = ext_enable_in;
        dec_nxt.src_addr = {5'h00, w[6:0]};
        dec_nxt.two_word = ext_enable_in;
      end
      // Absolute call, pointer load and jump: double-word
      16'b1110_110?_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.fast = w[cid_pkg::CALL_FAST_BIT];
        dec_nxt.lit_width = cid_pkg::CID_LW_20;
        dec_nxt.prog_addr = {12'h000, w[7:0]};
        dec_nxt.two_word = 1'b1;
      end
      16'b1110_1110_00??_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_LIT;
        dec_nxt.ptr_sel = w[cid_pkg::LFSR_SEL_LSB +: 2];
        dec_nxt.literal = {8'h00, w[3:0], 8'h00};
        dec_nxt.lit_width = cid_pkg::CID_LW_12;
        dec_nxt.two_word = 1'b1;
      end
      16'b1110_1111_????_????: begin
        dec_nxt.cls = cid_pkg::CID_CL_CTRL;
        dec_nxt.lit_width = cid_pkg::CID_LW_20;
        dec_nxt.prog_addr = {12'h000, w[7:0]};
        dec_nxt.two_word = 1'b1;
      end
      // Stray second word or unused code runs as a no-op
      default: dec_nxt.cls = cid_pkg::CID_CL_NOP;
    endcase
  end

  // ****************************************************************
  // Second-word merge
  // ****************************************************************
  // Only the low twelve bits of the second word carry operand data
  always_comb begin
    merged = dec_r;
    merged.word = w;
    casez (dec_r.word[15:8])
      8'b1100_????: merged.dst_addr = w[11:0];
      8'b1110_1011: merged.dst_addr = dec_r.word[7]
                                      ? {5'h00, w[6:0]} : w[11:0];
      8'b1110_1110: merged.literal[7:0] = w[7:0];
      8'b1110_11?1,
      8'b1110_110?: begin
        merged.literal = {w[11:0], dec_r.word[7:0]};
        merged.prog_addr = {w[11:0], dec_r.word[7:0]};
        merged.pc_change = 1'b1;
      end
      default: merged.dst_addr = dec_r.dst_addr;
    endcase
    // Malformed second word degrades the pair to a no-op
    if (w[15:12] != cid_pkg::WORD2_MARK) begin
      merged = '0;
      merged.word = w;
    end
  end

  // ****************************************************************
  // Cycle control
  // ****************************************************************
  // Taken test or jump in a one-word instruction drops the prefetch
  assign redirect = (state_r != cid_pkg::CID_ST_FLUSH) & !dec_r.two_word
                  & (dec_r.pc_change | (dec_r.cond & cond_true_in));

  // Skip over a pair ends up three cycles: the orphan second word
  // decodes as a no-op on its own, so no extra counter is needed.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= cid_pkg::CID_ST_EXEC;
      dec_r <= '0;
    end else if (cycle_end) begin
      unique case (state_r)
        cid_pkg::CID_ST_EXEC: begin
          if (dec_r.two_word) begin
            state_r <= cid_pkg::CID_ST_WORD2;
            dec_r <= merged;
          end else if (redirect) begin
            state_r <= cid_pkg::CID_ST_FLUSH;
            dec_r <= '0;
          end else begin
            dec_r <= dec_nxt;
          end
        end
        cid_pkg::CID_ST_WORD2: begin
          state_r <= cid_pkg::CID_ST_EXEC;
          dec_r <= dec_nxt;
        end
        cid_pkg::CID_ST_FLUSH: begin
          state_r <= cid_pkg::CID_ST_EXEC;
          dec_r <= dec_nxt;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Only flags named by the decoded mask take the ALU result
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      status_r <= cid_pkg::STATUS_RST;
    end else if (cycle_end && state_r != cid_pkg::CID_ST_FLUSH) begin
      status_r <= (status_r & ~dec_r.flag_mask)
                | (alu_flags_in & dec_r.flag_mask);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign phase_out = phase_r;
  assign cycle_end_out = cycle_end;
  assign fetch_take_out = cycle_end;
  assign discard_out = cycle_end & (state_r == cid_pkg::CID_ST_EXEC)
                     & redirect;
  assign flush_out = (state_r == cid_pkg::CID_ST_FLUSH);
  assign word2_out = (state_r == cid_pkg::CID_ST_WORD2);
  assign dec_out = dec_r;
  assign flags_out = status_r;

endmodule // cid_decode

// [verilog/cid_pkg.sv]
package cid_pkg;

  // ****************************************************************
  // Word geometry and field positions
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [3:0] WORD2_MARK = 4'hF;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BITNUM_LSB = 9;
  localparam int CALL_FAST_BIT = 8;
  localparam int RET_FAST_BIT = 0;
  localparam int LFSR_SEL_LSB = 4;
  localparam int ADDFSR_SEL_LSB = 6;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  localparam int QUARTERS = 4;

  typedef enum logic [3:0] {
    CID_Q1 = 4'h1,
    CID_Q2 = 4'h2,
    CID_Q3 = 4'h4,
    CID_Q4 = 4'h8
  } cid_phase_t;

  typedef enum logic [2:0] {
    CID_ST_EXEC = 3'h1,
    CID_ST_WORD2 = 3'h2,
    CID_ST_FLUSH = 3'h4
  } cid_state_t;

  // ****************************************************************
  // Decoded instruction
  // ****************************************************************
  typedef enum logic [2:0] {
    CID_CL_NOP = 3'h0,
    CID_CL_BYTE = 3'h1,
    CID_CL_BIT = 3'h2,
    CID_CL_LIT = 3'h3,
    CID_CL_CTRL = 3'h4,
    CID_CL_MOVE = 3'h5
  } cid_class_t;

  typedef enum logic [1:0] {
    CID_LW_8 = 2'h0,
    CID_LW_12 = 2'h1,
    CID_LW_20 = 2'h2
  } cid_lw_t;

  // Codes equal the two mode bits of the table instructions
  typedef enum logic [1:0] {
    CID_TBL_NONE = 2'h0,
    CID_TBL_POSTINC = 2'h1,
    CID_TBL_POSTDEC = 2'h2,
    CID_TBL_PREINC = 2'h3
  } cid_tbl_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cid_flags_t;

  localparam logic [4:0] FL_NONE = 5'h00;
  localparam logic [4:0] FL_ALL = 5'h1F;
  localparam logic [4:0] FL_ZN = 5'h14;
  localparam logic [4:0] FL_CZN = 5'h15;
  localparam logic [4:0] FL_Z = 5'h04;
  localparam logic [4:0] FL_C = 5'h01;
  localparam logic [4:0] STATUS_RST = 5'h00;

  typedef struct packed {
    logic [15:0] word;
    cid_class_t cls;
    logic [7:0] f_addr;
    logic dest_file;
    logic bank_sel;
    logic [2:0] bit_num;
    logic [1:0] ptr_sel;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [19:0] literal;
    cid_lw_t lit_width;
    logic [19:0] prog_addr;
    logic rel_addr;
    logic fast;
    cid_tbl_t tbl_mode;
    logic two_word;
    logic cond;
    logic pc_change;
    logic extended;
    cid_flags_t flag_mask;
  } cid_dec_t;

endpackage
